/* File: hw/timer8_params.svh */
// constants for the 8-bit waveform timer
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH

// counter extremes, step and turn values, reset loads
`define CNT_BOTTOM 8'h00
`define CNT_ONE 8'h01
`define CNT_MAX 8'hff
`define CNT_TURN 8'hfe
`define RST_CNT 8'h00
`define RST_OCR 8'h00

// wave mode field codes
`define WAVE_NORMAL 2'h0
`define WAVE_PHASE 2'h1
`define WAVE_CTC 2'h2
`define WAVE_FAST 2'h3

// output action field codes
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

// clock select codes and prescaler masks
`define PS_WIDTH 10
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV32 3'h3
`define CS_DIV64 3'h4
`define CS_DIV128 3'h5
`define CS_DIV256 3'h6
`define CS_DIV1024 3'h7
`define PS_MASK1 10'h000
`define PS_MASK8 10'h007
`define PS_MASK32 10'h01f
`define PS_MASK64 10'h03f
`define PS_MASK128 10'h07f
`define PS_MASK256 10'h0ff
`define PS_MASK1024 10'h3ff

`endif

/* File: hw/timer8_pkg.sv */
// types shared by the waveform timer modules
`include "timer8_params.svh"
package timer8_pkg;
	// count direction, one-hot
	typedef enum logic [1:0] {
		DIR_UP   = 2'b01,
		DIR_DOWN = 2'b10
	} count_dir_e;

	// waveform core state
	typedef struct packed {
		logic [7:0] cnt;     // running count
		logic [7:0] ocr;     // active compare value
		logic [7:0] ocr_buf; // software-side compare copy
		count_dir_e dir;     // slope direction
		logic       blk;     // match block after count write
		logic       ocf;     // compare match flag
		logic       tov;     // overflow flag
		logic       oc;      // compare output register
	} wave_state_s;

	// prescaler state
	typedef struct packed {
		logic [`PS_WIDTH-1:0] div;  // free divider
		logic                 tick; // timer clock enable
	} presc_state_s;

	// pin drive state
	typedef struct packed {
		logic val; // level on pin
		logic oe;  // pin driven
	} pin_state_s;
endpackage

/* File: hw/timer_prescaler.sv */
// prescaler producing the timer clock enable
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"
module timer_prescaler
	import timer8_pkg::*;
(
	input  wire logic       sys_clk,    // i/o clock
	input  wire logic       rstn,       // async reset, low
	input  wire logic [2:0] clk_select, // division choice
	output logic            timer_tick  // one-cycle enable
);
	presc_state_s s_q, s_d;           // registered state
	logic [`PS_WIDTH-1:0] mask;       // low-bit mask of divider

	// divider step and enable decode
	always_comb begin
		s_d = s_q;
		unique case (clk_select)
			`CS_DIV1:   mask = `PS_MASK1;
			`CS_DIV8:   mask = `PS_MASK8;
			`CS_DIV32:  mask = `PS_MASK32;
			`CS_DIV64:  mask = `PS_MASK64;
			`CS_DIV128: mask = `PS_MASK128;
			`CS_DIV256: mask = `PS_MASK256;
			default:    mask = `PS_MASK1024;
		endcase
		// stopped timer holds the divider cleared
		if (clk_select == `CS_STOP) begin
			s_d.div  = '0;
			s_d.tick = 1'b0;
		end else begin
			s_d.div  = s_q.div + 1'b1;
			s_d.tick = (s_q.div & mask) == mask;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign timer_tick = s_q.tick;

	chk_stop_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
		clk_select == `CS_STOP |=> !timer_tick)
		else $error("tick while timer stopped");
endmodule
`default_nettype wire

/* File: hw/compare_pin_drive.sv */
// port pin override by the compare output
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"
module compare_pin_drive
	import timer8_pkg::*;
(
	input  wire logic       sys_clk,        // i/o clock
	input  wire logic       rstn,           // async reset, low
	input  wire logic       compare_output, // waveform register
	input  wire logic [1:0] output_action,  // action field
	input  wire logic       port_data,      // general port value
	input  wire logic       pin_dir_out,    // direction bit
	output logic            pin_out,        // pin level
	output logic            pin_oe          // pin driven
);
	pin_state_s s_q, s_d; // registered pin state

	// any non-zero action hands the pin to the waveform
	always_comb begin
		s_d     = s_q;
		s_d.val = (output_action != `ACT_OFF) ? compare_output : port_data;
		s_d.oe  = pin_dir_out;
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_out = s_q.val;
	assign pin_oe  = s_q.oe;

	chk_pin_gated: assert property (@(posedge sys_clk) disable iff (!rstn)
		!pin_dir_out |=> !pin_oe)
		else $error("pin driven while direction is input");
endmodule
`default_nettype wire

/* File: hw/timer8_waveform_modes.sv */
// 8-bit timer with ctc, fast pwm and phase-correct pwm waveforms
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"
module timer8_waveform_modes
	import timer8_pkg::*;
(
	input  wire logic       sys_clk,             // i/o clock, 50 mhz
	input  wire logic       rstn,                // async reset, low
	input  wire logic [2:0] clk_select,          // prescaler choice
	input  wire logic [1:0] wave_mode_field,     // counting mode
	input  wire logic [1:0] output_action_field, // output action
	input  wire logic       compare_wr,          // compare write strobe
	input  wire logic [7:0] compare_wr_data,     // compare write data
	input  wire logic       count_wr,            // count write strobe
	input  wire logic [7:0] count_wr_data,       // count write data
	input  wire logic       match_flag_clr,      // clear match flag
	input  wire logic       overflow_flag_clr,   // clear overflow flag
	input  wire logic       port_data,           // general port level
	input  wire logic       pin_dir_out,         // direction bit
	output logic [7:0]      count_value,         // current count
	output logic [7:0]      compare_value,       // compare as software sees it
	output logic [7:0]      compare_active,      // compare in use
	output logic            compare_match_flag,  // sticky match flag
	output logic            overflow_flag,       // sticky overflow flag
	output logic            compare_output,      // waveform register
	output logic            count_up,            // slope is rising
	output logic            timer_tick,          // timer clock enable
	output logic            pin_out,             // pin level
	output logic            pin_oe               // pin driven
);
	wave_state_s s_q, s_d; // registered core state
	logic        tick;     // prescaled enable
	logic        top_hit;  // count at max
	logic        match;    // unblocked compare equality
	logic        pwm;      // either pwm mode
	logic        act_pwm;  // clear or set action

	// normal, ctc and fast pwm action on a compare match
	function automatic logic act_match(input logic [1:0] act, input logic oc);
		logic r;
		r = oc;
		unique case (act)
			`ACT_TOGGLE: r = ~oc;
			`ACT_CLEAR:  r = 1'b0;
			`ACT_SET:    r = 1'b1;
			`ACT_OFF:    r = oc;
		endcase
		return r;
	endfunction

	// phase pwm level for an up or down match
	function automatic logic pc_level(input logic [1:0] act, input logic up);
		logic r;
		r = (act == `ACT_SET) ? up : ~up;
		return r;
	endfunction

	// timer clock enable source
	timer_prescaler u_presc (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.clk_select (clk_select),
		.timer_tick (tick)
	);

	// pin override and direction gating
	compare_pin_drive u_pin (
		.sys_clk        (sys_clk),
		.rstn           (rstn),
		.compare_output (s_q.oc),
		.output_action  (output_action_field),
		.port_data      (port_data),
		.pin_dir_out    (pin_dir_out),
		.pin_out        (pin_out),
		.pin_oe         (pin_oe)
	);

	// next-state logic for counter, compare, flags and output
	always_comb begin
		s_d     = s_q;
		top_hit = s_q.cnt == `CNT_MAX;
		// a count write blocks the match on the next timer clock
		match   = (s_q.cnt == s_q.ocr) && !s_q.blk;
		pwm     = (wave_mode_field == `WAVE_PHASE) || (wave_mode_field == `WAVE_FAST);
		act_pwm = output_action_field[1];

		// flag clears first so a same-cycle set wins
		if (match_flag_clr) begin
			s_d.ocf = 1'b0;
		end
		if (overflow_flag_clr) begin
			s_d.tov = 1'b0;
		end

		// compare writes: buffered in pwm, direct otherwise
		if (compare_wr) begin
			s_d.ocr_buf = compare_wr_data;
			if (!pwm) begin
				s_d.ocr = compare_wr_data;
			end
		end

		// everything in this block moves only on the timer enable
		if (tick) begin
			s_d.blk = 1'b0;
			if (match) begin
				s_d.ocf = 1'b1;
			end
			unique case (wave_mode_field)
				`WAVE_NORMAL: begin
					// plain up count, wraps at max
					s_d.cnt = s_q.cnt + `CNT_ONE;
					s_d.dir = DIR_UP;
					if (top_hit) begin
						s_d.tov = 1'b1;
					end
					if (match) begin
						s_d.oc = act_match(output_action_field, s_q.oc);
					end
				end
				`WAVE_CTC: begin
					// compare acts as top; a missed match runs on to max
					s_d.dir = DIR_UP;
					if (match) begin
						s_d.cnt = `CNT_BOTTOM;
						s_d.oc  = act_match(output_action_field, s_q.oc);
					end else begin
						s_d.cnt = s_q.cnt + `CNT_ONE;
					end
					if (top_hit) begin
						s_d.tov = 1'b1;
					end
					// match sets the flag once per period
					s_d.ocf = s_d.ocf | match;
				end
				`WAVE_FAST: begin
					// single slope: 256 timer clocks a period
					s_d.cnt = s_q.cnt + `CNT_ONE;
					s_d.dir = DIR_UP;
					if (top_hit) begin
						s_d.tov = 1'b1;
						s_d.ocr = s_q.ocr_buf;
					end
					// with clear or set action a match at max compare is ignored, level set at bottom
					if (top_hit && act_pwm) begin
						s_d.oc = (output_action_field == `ACT_CLEAR);
					end else if (match) begin
						s_d.oc = act_match(output_action_field, s_q.oc);
					end
				end
				`WAVE_PHASE: begin
					// dual slope over the full 8-bit range
					if (s_q.dir == DIR_UP) begin
						if (top_hit) begin
							// one clock at max, then turn down
							s_d.cnt = `CNT_TURN;
							s_d.dir = DIR_DOWN;
							s_d.ocr = s_q.ocr_buf;
							// level at max follows the new compare
							if (act_pwm) begin
								s_d.oc = pc_level(output_action_field,
									s_q.ocr_buf != `CNT_MAX);
							end
						end else begin
							s_d.cnt = s_q.cnt + `CNT_ONE;
							if (match && act_pwm) begin
								s_d.oc = pc_level(output_action_field, 1'b1);
							end
						end
					end else begin
						if (s_q.cnt == `CNT_BOTTOM) begin
							// bottom turn; a match here counts as rising
							s_d.cnt = `CNT_ONE;
							s_d.dir = DIR_UP;
							if (match && act_pwm) begin
								s_d.oc = pc_level(output_action_field, 1'b1);
							end
						end else begin
							s_d.cnt = s_q.cnt - `CNT_ONE;
							if (s_q.cnt == `CNT_ONE) begin
								s_d.tov = 1'b1;
							end
							if (match && act_pwm) begin
								s_d.oc = pc_level(output_action_field, 1'b0);
							end
						end
					end
				end
			endcase
		end

		// non-pwm modes keep the buffer equal to the active value
		if (!pwm && !compare_wr) begin
			s_d.ocr_buf = s_d.ocr;
		end

		// software count write overrides the step
		if (count_wr) begin
			s_d.cnt = count_wr_data;
			s_d.blk = 1'b1;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q         <= '0;
			s_q.cnt     <= `RST_CNT;
			s_q.ocr     <= `RST_OCR;
			s_q.ocr_buf <= `RST_OCR;
			s_q.dir     <= DIR_UP;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state
	assign count_value        = s_q.cnt;
	assign compare_value      = s_q.ocr_buf;
	assign compare_active     = s_q.ocr;
	assign compare_match_flag = s_q.ocf;
	assign overflow_flag      = s_q.tov;
	assign compare_output     = s_q.oc;
	assign count_up           = s_q.dir == DIR_UP;
	assign timer_tick         = tick;

	// ctc clears after equality
	chk_ctc_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_CTC && tick && !count_wr && match
		|=> count_value == `CNT_BOTTOM)
		else $error("ctc did not clear on compare");

	// ctc missed compare keeps counting
	chk_ctc_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_CTC && tick && !count_wr && !match && !top_hit
		|=> count_value == $past(count_value) + `CNT_ONE)
		else $error("ctc did not run past missed compare");

	// match flag follows equality by one timer clock
	chk_match_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		tick && match |=> compare_match_flag)
		else $error("match flag not set after equality");

	// no flag without equality
	chk_flag_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
		!compare_match_flag ##1 compare_match_flag |-> $past(tick) && $past(match))
		else $error("match flag set without a match");

	// ctc toggle action
	chk_ctc_toggle: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_CTC && output_action_field == `ACT_TOGGLE && tick && match
		|=> compare_output != $past(compare_output))
		else $error("ctc toggle missing");

	// overflow at roll in single-slope modes
	chk_roll_ovf: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field != `WAVE_PHASE && tick && top_hit |=> overflow_flag)
		else $error("overflow flag missing at roll");

	// fast pwm wraps to bottom after max
	chk_fast_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_FAST && tick && top_hit && !count_wr
		|=> count_value == `CNT_BOTTOM)
		else $error("fast pwm did not wrap");

	// fast pwm bottom level for non-inverted
	chk_fast_bottom: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_FAST && output_action_field == `ACT_CLEAR && tick && top_hit
		|=> compare_output)
		else $error("fast pwm not set at bottom");

	// phase pwm turns after one clock at max
	chk_phase_turn: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_PHASE && tick && top_hit && !count_wr && count_up
		|=> count_value == `CNT_TURN && !count_up)
		else $error("phase pwm did not turn at max");

	// phase pwm overflow on reaching bottom
	chk_phase_ovf: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_PHASE && tick && !count_up && count_value == `CNT_ONE
		|=> overflow_flag)
		else $error("phase pwm overflow missing at bottom");

	// fast pwm compare writes wait for the boundary
	chk_buffered: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_FAST && !(tick && top_hit) |=> $stable(compare_active))
		else $error("fast pwm compare changed mid period");

	// count and output do not move without the enable
	chk_idle_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		!tick && !count_wr |=> $stable(count_value) && $stable(compare_output))
		else $error("timer moved without enable");

	// phase pwm turns up after one clock at bottom
	chk_phase_bottom: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_PHASE && tick && !count_wr && !count_up && count_value == `CNT_BOTTOM
		|=> count_value == `CNT_ONE && count_up)
		else $error("phase pwm did not turn at bottom");

	// non-inverted phase pwm clears on a rising match
	chk_phase_rise: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_PHASE && output_action_field == `ACT_CLEAR && tick && match
		&& count_up && !top_hit |=> !compare_output)
		else $error("phase pwm output not cleared on rising match");

	// non-inverted phase pwm sets on a falling match
	chk_phase_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_PHASE && output_action_field == `ACT_CLEAR && tick && match
		&& !count_up && count_value != `CNT_BOTTOM |=> compare_output)
		else $error("phase pwm output not set on falling match");

	// phase pwm compare loads only at the top turn
	chk_phase_buffered: assert property (@(posedge sys_clk) disable iff (!rstn)
		wave_mode_field == `WAVE_PHASE && !(tick && top_hit && count_up) |=> $stable(compare_active))
		else $error("phase pwm compare changed mid period");
endmodule
`default_nettype wire

/* File: tb/test_timer8_waveform_modes.sv */
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"
module test_timer8_waveform_modes;
	logic       sys_clk = 1'b0; // i/o clock
	logic       rstn = 1'b0;    // reset, low
	logic [2:0] cs = 3'h1;      // clock select
	logic [1:0] mode = 2'h0;    // wave mode
	logic [1:0] act = 2'h0;     // output action
	logic       cwr = 1'b0;     // compare strobe
	logic       nwr = 1'b0;     // count strobe
	logic [7:0] wd = 8'h00;     // write data, both strobes
	logic       mclr = 1'b0;    // match flag clear
	logic       oclr = 1'b0;    // overflow clear
	logic       pdat = 1'b0;    // port level
	logic       pdir = 1'b0;    // pin direction
	logic [7:0] cnt;            // count seen
	logic [7:0] cval;           // compare, software view
	logic [7:0] cact;           // compare in use
	logic       mflg;           // match flag
	logic       oflg;           // overflow flag
	logic       oc;             // waveform register
	logic       up;             // rising slope
	logic       tick;           // timer enable
	logic       pout;           // pin level
	logic       poe;            // pin enable
	int         mismatches = 0; // failed compares
	int         num_checks = 0; // all compares
	int         n;              // tick counts
	int         m;              // partial tick count
	logic [7:0] v;              // chosen compare
	logic [7:0] c0;             // remembered value
	logic [1:0] a;              // chosen action
	logic       o;              // remembered output

	timer8_waveform_modes i_timer8_waveform_modes (
		.sys_clk(sys_clk), .rstn(rstn), .clk_select(cs), .wave_mode_field(mode),
		.output_action_field(act), .compare_wr(cwr), .compare_wr_data(wd),
		.count_wr(nwr), .count_wr_data(wd), .match_flag_clr(mclr),
		.overflow_flag_clr(oclr), .port_data(pdat), .pin_dir_out(pdir),
		.count_value(cnt), .compare_value(cval), .compare_active(cact),
		.compare_match_flag(mflg), .overflow_flag(oflg), .compare_output(oc),
		.count_up(up), .timer_tick(tick), .pin_out(pout), .pin_oe(poe)
	);

	// free-running 50 mhz clock
	always #10 sys_clk = ~sys_clk;

	// compare and count
	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task summarize;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// settle point just after an edge
	task cyc;
		@(posedge sys_clk);
		#1;
	endtask

	// level inputs change off the edge
	task cfg(input logic [1:0] wm, input logic [1:0] oa, input logic [2:0] sel);
		@(posedge sys_clk);
		#2;
		mode = wm;
		act = oa;
		cs = sel;
	endtask

	// one-cycle strobes, mask is {compare, count, match clr, ovf clr}
	task pulse(input logic [3:0] mask, input logic [7:0] d);
		@(posedge sys_clk);
		#2;
		{cwr, nwr, mclr, oclr} = mask;
		wd = d;
		@(posedge sys_clk);
		#2;
		{cwr, nwr, mclr, oclr} = 4'h0;
	endtask

	// let k timer enables pass; enable seen mid-cycle acts at next edge
	task tk(input int k);
		logic t;
		while (k > 0) begin
			t = tick;
			cyc();
			if (t === 1'b1) k--;
		end
	endtask

	// ticks until the count shows x, bounded
	task wcnt(input logic [7:0] x, output int c);
		c = 0;
		while (cnt !== x && c < 600) begin
			tk(1);
			c++;
		end
		// a count that never arrives is a failure in itself
		if (cnt !== x) mismatches++;
	endtask

	// cycles to the next enable
	task ntick(output int c);
		c = 0;
		do begin
			cyc();
			c++;
		end while (tick !== 1'b1 && c < 3000);
		// an enable that never comes counts against the run
		if (tick !== 1'b1) mismatches++;
	endtask

	// expected division per clock select
	function automatic int div_of(input logic [2:0] s);
		case (s)
			3'h1: return 1;
			3'h2: return 8;
			3'h3: return 32;
			3'h4: return 64;
			3'h5: return 128;
			3'h6: return 256;
			default: return 1024;
		endcase
	endfunction

	// watchdog, well beyond the expected run length
	initial begin
		#(20 * 60000);
		mismatches++;
		summarize();
	end

	// main sequence
	initial begin
		void'($urandom(32'h6d51));
		repeat (16) @(posedge sys_clk);
		#2 rstn = 1'b1;
		// every prescaler ratio; count frozen between enables
		for (int s = 1; s < 8; s++) begin
			cfg(`WAVE_NORMAL, `ACT_OFF, 3'(s));
			ntick(n);
			ntick(n);
			check(n, div_of(3'(s)));
			cyc();
			c0 = cnt + 8'(s == 1);
			ntick(n);
			check(cnt, c0);
		end
		// stopped timer: no enable, no movement
		cfg(`WAVE_NORMAL, `ACT_OFF, `CS_STOP);
		repeat (3) cyc();
		c0 = cnt;
		repeat (40) begin
			cyc();
			check(tick, 1'b0);
		end
		check(cnt, c0);
		// clear-on-compare, smallest top first, then random tops
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h01 : 8'(1 + $urandom % 40);
			cfg(`WAVE_CTC, `ACT_TOGGLE, `CS_STOP);
			pulse(4'b1000, v);
			check(cact, v);
			pulse(4'b0111, 8'h00);
			cfg(`WAVE_CTC, `ACT_TOGGLE, `CS_DIV1);
			wcnt(v, n);
			check(mflg, 1'b0);
			o = oc;
			tk(1);
			check(cnt, 8'h00);
			check(mflg, 1'b1);
			check(oc, !o);
			wcnt(v, n);
			check(n, v);
		end
		// top written below the count: wrap through max first
		cfg(`WAVE_CTC, `ACT_TOGGLE, `CS_STOP);
		pulse(4'b1000, 8'h14);
		pulse(4'b0111, 8'h1e);
		cfg(`WAVE_CTC, `ACT_TOGGLE, `CS_DIV1);
		wcnt(8'hff, n);
		check(mflg, 1'b0);
		check(oflg, 1'b0);
		tk(1);
		check(cnt, 8'h00);
		check(oflg, 1'b1);
		wcnt(8'h14, n);
		tk(1);
		check(mflg, 1'b1);
		// fast pwm with clear, set and toggle actions and a random duty
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? `ACT_CLEAR : (i == 1) ? `ACT_SET : `ACT_TOGGLE;
			v = 8'(1 + $urandom % 254);
			cfg(`WAVE_FAST, a, `CS_DIV1);
			wcnt(8'h10, n);
			c0 = cact;
			pulse(4'b1000, v);
			check(cact, c0);
			check(cval, v);
			pulse(4'b0001, 8'h00);
			wcnt(8'hff, n);
			tk(1);
			check(cnt, 8'h00);
			check(oflg, 1'b1);
			check(cact, v);
			if (a != `ACT_TOGGLE) check(oc, a == `ACT_CLEAR);
			o = oc;
			wcnt(v, n);
			tk(1);
			check(oc, a == `ACT_CLEAR ? 1'b0 : a == `ACT_SET ? 1'b1 : !o);
			wcnt(8'hff, n);
			tk(1);
			wcnt(8'hff, n);
			check(n, 255);
		end
		// fast pwm extremes: spike at bottom, steady at max
		cfg(`WAVE_FAST, `ACT_CLEAR, `CS_DIV1);
		pulse(4'b1000, 8'h00);
		wcnt(8'hff, n);
		tk(1);
		check(oc, 1'b1);
		tk(1);
		check(oc, 1'b0);
		pulse(4'b1000, 8'hff);
		wcnt(8'hff, n);
		tk(1);
		for (int k = 0; k < 4; k++) begin
			wcnt(8'(k * 85), n);
			check(oc, 1'b1);
		end
		// phase-correct, both polarities
		for (int i = 0; i < 2; i++) begin
			v = 8'(16 + $urandom % 224);
			cfg(`WAVE_PHASE, i ? `ACT_SET : `ACT_CLEAR, `CS_DIV1);
			pulse(4'b1000, v);
			wcnt(8'hff, n);
			tk(1);
			check(cnt, 8'hfe);
			check(up, 1'b0);
			check(cact, v);
			wcnt(v, n);
			tk(1);
			check(oc, i == 0);
			pulse(4'b0001, 8'h00);
			wcnt(8'h01, n);
			check(oflg, 1'b0);
			tk(1);
			check(cnt, 8'h00);
			check(oflg, 1'b1);
			tk(1);
			check(up, 1'b1);
			wcnt(v, m);
			tk(1);
			check(oc, i == 1);
			wcnt(8'h00, n);
			check(m + n + 2, 510);
		end
		// phase-correct extremes give steady levels, non-inverted
		cfg(`WAVE_PHASE, `ACT_CLEAR, `CS_DIV1);
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'hff : 8'h00;
			pulse(4'b1000, v);
			wcnt(8'hff, n);
			tk(1);
			wcnt(8'hff, n);
			tk(1);
			for (int k = 0; k < 4; k++) begin
				wcnt(k == 1 ? 8'h00 : k == 3 ? 8'hff : 8'h80, n);
				check(oc, v[0]);
			end
		end
		// leaving max: output takes the up-match level at max
		pulse(4'b1000, 8'h40);
		wcnt(8'hff, n);
		tk(1);
		check(oc, 1'b0);
		// count placed above compare while rising: missed match still applied
		wcnt(8'h00, n);
		tk(2);
		check(oc, 1'b1);
		pulse(4'b0100, 8'hf0);
		wcnt(8'hff, n);
		tk(1);
		check(cnt, 8'hfe);
		check(oc, 1'b0);
		// pin override and direction, timer frozen so the level holds
		cfg(`WAVE_PHASE, `ACT_CLEAR, `CS_STOP);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			#2;
			act = 2'(i);
			pdir = i[2];
			pdat = 1'($urandom);
			repeat (3) cyc();
			check(poe, pdir);
			if (pdir) check(pout, act == `ACT_OFF ? pdat : oc);
		end
		summarize();
	end
endmodule
`default_nettype wire
